// ---- cbt_pkg.sv ----
// Shared constants and types for the CAN bit timing configuration block
`default_nettype none
package cbt_pkg;
  // ----------------------------------------------------------------
  // Clock and time
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_FILT_NS  = 100;
  localparam int WAKE_FILT_CYC =
    ((WAKE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
    (WAKE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] TIMING_OFS  = 8'h00;
  localparam logic [7:0] FILTER_OFS  = 8'h04;
  localparam logic [7:0] CONTROL_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS  = 8'h0C;

  // Bit timing register fields
  localparam int WAKE_BIT    = 22;
  localparam int PH2_LSB     = 16;
  localparam int PH2SEL_BIT  = 15;
  localparam int VOTE_BIT    = 14;
  localparam int PH1_LSB     = 11;
  localparam int PROP_LSB    = 8;
  localparam int SJW_LSB     = 6;
  localparam int PRESC_LSB   = 0;
  // Control register: operating state field
  localparam int OPSTATE_LSB = 21;
  localparam logic [2:0] OPSTATE_CONFIG = 3'h4;
  localparam logic [2:0] OPSTATE_RESET  = 3'h4;
  // Status register fields
  localparam int ST_QPB_LSB = 8;
  localparam int ST_SEG_LSB = 16;

  // Information processing time as a length code (2 quanta)
  localparam logic [2:0] IPT_CODE      = 3'h1;
  localparam logic [1:0] MASK_RESERVED = 2'h3;
  localparam int         NUM_FILTERS   = 4;
  localparam int         PRESC_W       = 6;
  localparam int         TQCNT_W       = 7;

  typedef struct packed {
    logic                wake_line_filter_en;
    logic [2:0]          phase2_len;
    logic                phase2_free_select;
    logic                three_point_vote;
    logic [2:0]          phase1_len;
    logic [2:0]          propagation_len;
    logic [1:0]          resync_jump_width;
    logic [PRESC_W-1:0]  quantum_prescale;
  } cbt_timing_type;

  localparam cbt_timing_type TIMING_RESET = 20'h00000;

  typedef struct packed {
    logic       filter_on;
    logic [1:0] mask_pick;
    logic [4:0] dest_buffer_pick;
  } cbt_filter_type;

  localparam logic [31:0] FILTER_RESET = 32'h00000000;

  typedef enum logic [1:0] {SEG_SYNC, SEG_PROP, SEG_PH1, SEG_PH2} cbt_seg_type;
endpackage
`default_nettype wire

// ---- cbt_quantum_gen.sv ----
// Time quantum prescaler and nominal bit segment sequencer
`default_nettype none
module cbt_quantum_gen
  import cbt_pkg::*;
(
  input  wire logic           hclk,
  input  wire logic           hresetn,
  input  wire logic           run,
  input  wire logic           hard_sync,
  input  wire cbt_timing_type timing,
  input  wire logic [2:0]     ph2_eff,
  output logic                tq_en,
  output logic                sample_pt,
  output cbt_seg_type         seg,
  output logic [2:0]          q_cnt
);
  logic [TQCNT_W-1:0] pre_cnt, next_pre_cnt, tq_last;
  cbt_seg_type        next_seg;
  logic [2:0]         next_q_cnt, seg_last;

  // Quantum lasts 2 x (prescale + 1) module clocks
  assign tq_last = TQCNT_W'({timing.quantum_prescale, 1'b1});
  assign tq_en   = run && !hard_sync && (pre_cnt == tq_last);

  always_comb begin
    case (seg)
      SEG_SYNC: seg_last = 3'h0;
      SEG_PROP: seg_last = timing.propagation_len;
      SEG_PH1:  seg_last = timing.phase1_len;
      default:  seg_last = ph2_eff;
    endcase
  end

  assign sample_pt = tq_en && (seg == SEG_PH1) && (q_cnt == seg_last);

  always_comb begin
    next_pre_cnt = pre_cnt;
    next_seg     = seg;
    next_q_cnt   = q_cnt;
    if (!run) begin
      next_pre_cnt = '0;
      next_seg     = SEG_SYNC;
      next_q_cnt   = '0;
    end else if (hard_sync) begin
      // Edge ends the sync quantum; bit restarts in propagation
      next_pre_cnt = '0;
      next_seg     = SEG_PROP;
      next_q_cnt   = '0;
    end else if (tq_en) begin
      next_pre_cnt = '0;
      if (q_cnt == seg_last) begin
        next_q_cnt = '0;
        case (seg)
          SEG_SYNC: next_seg = SEG_PROP;
          SEG_PROP: next_seg = SEG_PH1;
          SEG_PH1:  next_seg = SEG_PH2;
          default:  next_seg = SEG_SYNC;
        endcase
      end else begin
        next_q_cnt = q_cnt + 3'h1;
      end
    end else begin
      next_pre_cnt = pre_cnt + TQCNT_W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt <= '0;
      seg     <= SEG_SYNC;
      q_cnt   <= 3'h0;
    end else begin
      pre_cnt <= next_pre_cnt;
      seg     <= next_seg;
      q_cnt   <= next_q_cnt;
    end
  end

  tq_spacing_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tq_en |=> !tq_en) else $error("quantum shorter than two clocks");
  ph1_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sample_pt |-> seg == SEG_PH1 && q_cnt == timing.phase1_len)
    else $error("sample point not at end of phase 1");
  ph2_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (tq_en && seg == SEG_PH2 && q_cnt == ph2_eff) |=> seg == SEG_SYNC)
    else $error("phase 2 length wrong");
endmodule
`default_nettype wire

// ---- cbt_line_sampler.sv ----
// Receive line synchroniser, wake-up filter and bit sampler
`default_nettype none
module cbt_line_sampler
  import cbt_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic rx_pin,
  input  wire logic filt_en,
  input  wire logic vote3,
  input  wire logic tq_en,
  input  wire logic sample_pt,
  output logic      rx_stable,
  output logic      wake_level,
  output logic      rx_bit,
  output logic      rx_bit_valid
);
  localparam int FW = $clog2(WAKE_FILT_CYC + 1);
  logic [2:0]    sync_ff;
  logic          next_rx_stable, next_wake, next_bit, majority;
  logic [FW-1:0] filt_cnt, next_filt_cnt;
  logic [1:0]    hist, next_hist;

  // Stage 0 feeds only stage 1
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_ff <= 3'h7;
    end else begin
      sync_ff <= {sync_ff[1:0], rx_pin};
    end
  end

  assign majority = (hist[0] & hist[1]) | (hist[0] & rx_stable) | (hist[1] & rx_stable);

  always_comb begin
    next_rx_stable = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : rx_stable;
    next_filt_cnt  = filt_cnt;
    next_wake      = wake_level;
    next_hist      = tq_en ? {hist[0], rx_stable} : hist;
    next_bit       = rx_bit;
    if (!filt_en) begin
      next_wake     = rx_stable;
      next_filt_cnt = '0;
    end else if (rx_stable == wake_level) begin
      next_filt_cnt = '0;
    end else if (filt_cnt == FW'(WAKE_FILT_CYC - 1)) begin
      // Glitches shorter than the filter never reach wake-up
      next_wake     = rx_stable;
      next_filt_cnt = '0;
    end else begin
      next_filt_cnt = filt_cnt + FW'(1);
    end
    if (sample_pt) begin
      next_bit = vote3 ? majority : rx_stable;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_stable    <= 1'b1;
      wake_level   <= 1'b1;
      filt_cnt     <= '0;
      hist         <= 2'h3;
      rx_bit       <= 1'b1;
      rx_bit_valid <= 1'b0;
    end else begin
      rx_stable    <= next_rx_stable;
      wake_level   <= next_wake;
      filt_cnt     <= next_filt_cnt;
      hist         <= next_hist;
      rx_bit       <= next_bit;
      rx_bit_valid <= sample_pt;
    end
  end

  wake_direct_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !filt_en |=> wake_level == $past(rx_stable))
    else $error("unfiltered wake line does not follow receive line");
  wake_glitch_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (filt_en && $past(filt_en) && rx_stable != wake_level && filt_cnt == '0)
    |=> wake_level == $past(wake_level))
    else $error("wake filter passed a one cycle change");
  vote_pick_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sample_pt |=> rx_bit == ($past(vote3) ? $past(majority) : $past(rx_stable)))
    else $error("sampled bit not taken per sampling mode");
endmodule
`default_nettype wire

// ---- cbt_top.sv ----
// CAN bit timing configuration block with AHB-Lite register slave
`default_nettype none
module cbt_top
  import cbt_pkg::*;
(
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  input  wire logic                   rx_pin,
  input  wire logic [NUM_FILTERS-1:0] filter_match,
  output logic                        wake_level,
  output logic                        rx_bit,
  output logic                        rx_bit_valid,
  output logic                        tq_tick,
  output logic                        store_req,
  output logic      [4:0]             store_buf,
  output logic      [1:0]             store_mask
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cbt_timing_type timing, next_timing;
  cbt_filter_type [NUM_FILTERS-1:0] filt, next_filt;
  logic [2:0]  opstate, next_opstate;
  logic        dp_valid, next_dp_valid;
  logic        dp_write, next_dp_write;
  logic [7:0]  dp_addr, next_dp_addr;
  logic        rd_pend, next_rd_pend;
  logic [31:0] next_hrdata;
  logic        next_store_req;
  logic [4:0]  next_store_buf;
  logic [1:0]  next_store_mask;

  logic        addr_take, wr_commit, cfg_mode, run;
  logic [2:0]  ph2_auto, ph2_eff, wr_ph1;
  logic [4:0]  quanta_per_bit;
  logic        rx_stable, rx_prev, hard_sync, sample_pt;
  cbt_seg_type seg;
  logic [2:0]  q_cnt;
  logic [31:0] rd_word;

  // ----------------------------------------------------------------
  // Bus address and data phases
  // ----------------------------------------------------------------
  assign addr_take = hsel && htrans[1] && hready;
  assign wr_commit = dp_valid && dp_write && hready;
  assign hreadyout = !rd_pend;
  assign hresp     = 1'b0;

  always_comb begin
    next_dp_valid = dp_valid;
    next_dp_write = dp_write;
    next_dp_addr  = dp_addr;
    next_rd_pend  = 1'b0;
    if (hready) begin
      next_dp_valid = addr_take && (hsize == 3'h2);
      next_dp_write = hwrite;
      next_dp_addr  = {haddr[7:2], 2'b00};
      // Reads take one wait state so a write just ahead is seen
      next_rd_pend  = addr_take && !hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
      rd_pend  <= 1'b0;
    end else begin
      dp_valid <= next_dp_valid;
      dp_write <= next_dp_write;
      dp_addr  <= next_dp_addr;
      rd_pend  <= next_rd_pend;
    end
  end

  // ----------------------------------------------------------------
  // Bit timing and control registers
  // ----------------------------------------------------------------
  assign cfg_mode = (opstate == OPSTATE_CONFIG);
  assign run      = !cfg_mode;
  assign wr_ph1   = hwdata[PH1_LSB +: 3];
  assign ph2_auto = (wr_ph1 > IPT_CODE) ? wr_ph1 : IPT_CODE;

  always_comb begin
    next_timing  = timing;
    next_opstate = opstate;
    if (wr_commit && dp_addr == TIMING_OFS && cfg_mode) begin
      next_timing.wake_line_filter_en = hwdata[WAKE_BIT];
      next_timing.phase2_free_select  = hwdata[PH2SEL_BIT];
      next_timing.three_point_vote    = hwdata[VOTE_BIT];
      next_timing.phase1_len          = wr_ph1;
      next_timing.propagation_len     = hwdata[PROP_LSB +: 3];
      next_timing.resync_jump_width   = hwdata[SJW_LSB +: 2];
      next_timing.quantum_prescale    = hwdata[PRESC_LSB +: PRESC_W];
      // Freely programmable only with phase 2 free select set; otherwise hardware loads phase 2 itself
      next_timing.phase2_len = hwdata[PH2SEL_BIT] ? hwdata[PH2_LSB +: 3] : ph2_auto;
    end
    if (wr_commit && dp_addr == CONTROL_OFS) begin
      next_opstate = hwdata[OPSTATE_LSB +: 3];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timing  <= TIMING_RESET;
      opstate <= OPSTATE_RESET;
    end else begin
      timing  <= next_timing;
      opstate <= next_opstate;
    end
  end

  // Effective phase 2 length in use by the sequencer
  always_comb begin
    if (timing.phase2_free_select) begin
      ph2_eff = timing.phase2_len;
    end else if (timing.phase1_len > IPT_CODE) begin
      ph2_eff = timing.phase1_len;
    end else begin
      ph2_eff = IPT_CODE;
    end
  end

  assign quanta_per_bit = 5'h4 + 5'(timing.propagation_len)
                        + 5'(timing.phase1_len) + 5'(ph2_eff);

  // ----------------------------------------------------------------
  // Acceptance filter control bytes
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FILTERS; gi++) begin : g_filt
      always_comb begin
        next_filt[gi] = filt[gi];
        if (wr_commit && dp_addr == FILTER_OFS) begin
          next_filt[gi].filter_on = hwdata[8*gi+7];
          if (!filt[gi].filter_on) begin
            next_filt[gi].mask_pick        = hwdata[8*gi+5 +: 2];
            next_filt[gi].dest_buffer_pick = hwdata[8*gi +: 5];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt <= FILTER_RESET;
    end else begin
      filt <= next_filt;
    end
  end

  // ----------------------------------------------------------------
  // Store request from matching filters
  // ----------------------------------------------------------------
  // Lowest numbered enabled filter wins; reserved mask pick never matches
  always_comb begin
    next_store_req  = 1'b0;
    next_store_buf  = store_buf;
    next_store_mask = store_mask;
    for (int i = NUM_FILTERS - 1; i >= 0; i--) begin
      if (filter_match[i] && filt[i].filter_on && filt[i].mask_pick != MASK_RESERVED) begin
        next_store_req  = 1'b1;
        next_store_buf  = filt[i].dest_buffer_pick;
        next_store_mask = filt[i].mask_pick;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      store_req  <= 1'b0;
      store_buf  <= 5'h00;
      store_mask <= 2'h0;
    end else begin
      store_req  <= next_store_req;
      store_buf  <= next_store_buf;
      store_mask <= next_store_mask;
    end
  end

  // ----------------------------------------------------------------
  // Line sampling and bit sequencing
  // ----------------------------------------------------------------
  cbt_line_sampler u_sampler (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .rx_pin       (rx_pin),
    .filt_en      (timing.wake_line_filter_en),
    .vote3        (timing.three_point_vote),
    .tq_en        (tq_tick),
    .sample_pt    (sample_pt),
    .rx_stable    (rx_stable),
    .wake_level   (wake_level),
    .rx_bit       (rx_bit),
    .rx_bit_valid (rx_bit_valid)
  );

  // Recessive to dominant edge outside sync restarts the bit
  assign hard_sync = run && rx_prev && !rx_stable && (seg != SEG_SYNC);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_prev <= 1'b1;
    end else begin
      rx_prev <= rx_stable;
    end
  end

  cbt_quantum_gen u_qgen (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .run       (run),
    .hard_sync (hard_sync),
    .timing    (timing),
    .ph2_eff   (ph2_eff),
    .tq_en     (tq_tick),
    .sample_pt (sample_pt),
    .seg       (seg),
    .q_cnt     (q_cnt)
  );

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = 32'h00000000;
    if (dp_addr == TIMING_OFS) begin
      rd_word[WAKE_BIT]          = timing.wake_line_filter_en;
      rd_word[PH2_LSB +: 3]      = timing.phase2_len;
      rd_word[PH2SEL_BIT]        = timing.phase2_free_select;
      rd_word[VOTE_BIT]          = timing.three_point_vote;
      rd_word[PH1_LSB +: 3]      = timing.phase1_len;
      rd_word[PROP_LSB +: 3]     = timing.propagation_len;
      rd_word[SJW_LSB +: 2]      = timing.resync_jump_width;
      rd_word[PRESC_LSB +: PRESC_W] = timing.quantum_prescale;
    end else if (dp_addr == FILTER_OFS) begin
      rd_word = filt;
    end else if (dp_addr == CONTROL_OFS) begin
      rd_word[OPSTATE_LSB +: 3] = opstate;
    end else if (dp_addr == STATUS_OFS) begin
      rd_word[0] = rx_bit;
      rd_word[1] = wake_level;
      rd_word[2] = rx_stable;
      rd_word[ST_QPB_LSB +: 5] = quanta_per_bit;
      rd_word[ST_SEG_LSB +: 2] = seg;
    end
  end

  assign next_hrdata = rd_pend ? rd_word : hrdata;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else begin
      hrdata <= next_hrdata;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  timing_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_commit && dp_addr == TIMING_OFS && !cfg_mode) |=> $stable(timing))
    else $error("bit timing changed outside configuration state");
  ph2_auto_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_commit && dp_addr == TIMING_OFS && cfg_mode && !hwdata[PH2SEL_BIT])
    |=> timing.phase2_len >= timing.phase1_len && timing.phase2_len >= IPT_CODE
        && (timing.phase2_len == timing.phase1_len || timing.phase2_len == IPT_CODE))
    else $error("phase 2 not auto-loaded");
  ph2_sel_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !timing.phase2_free_select |-> ph2_eff >= timing.phase1_len && ph2_eff >= IPT_CODE)
    else $error("phase 2 below phase 1 or processing time");
  filt_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_commit && dp_addr == FILTER_OFS && filt[0].filter_on)
    |=> $stable(filt[0].mask_pick) && $stable(filt[0].dest_buffer_pick))
    else $error("filter fields changed while enabled");
  store_buf_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (filter_match[0] && filt[0].filter_on && filt[0].mask_pick != MASK_RESERVED)
    |=> store_req && store_buf == $past(filt[0].dest_buffer_pick))
    else $error("match not stored in destination buffer");
  mask_res_a: assert property (@(posedge hclk) disable iff (!hresetn)
    store_req |-> store_mask != MASK_RESERVED)
    else $error("reserved mask pick produced a store");
  read_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_take && !hwrite && hsize == 3'h2) |=> !hreadyout ##1 hreadyout)
    else $error("read wait state missing");
endmodule
`default_nettype wire

// ---- cbt_node_model.sv ----
// Behavioural remote node holding the bus dominant for a set number of clocks
`default_nettype none
module cbt_node_model (
  input  wire logic       hclk,
  input  wire logic       send,
  input  wire logic [7:0] pulse_cyc,
  output logic            rx_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left = 8'h00;
  // Recessive idle is the transceiver's pull to 1
  always @(posedge hclk) begin
    if (send) begin
      left <= pulse_cyc - 8'h01;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
    rx_pin <= !send && (left == 8'h00);
  end
endmodule
`default_nettype wire

// ---- test_cbt_top.sv ----
// Register-level testbench for the CAN bit timing configuration block
`default_nettype none
module test_cbt_top;
  import cbt_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_pin, send;
  logic wake_level, rx_bit, rx_bit_valid, tq_tick, store_req;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans, store_mask;
  logic [2:0]  hsize;
  logic [3:0]  filter_match;
  logic [4:0]  store_buf;
  logic [7:0]  pulse_cyc;
  int mismatches, comparisons, n, lo;
  cbt_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rx_pin(rx_pin), .filter_match(filter_match), .wake_level(wake_level),
    .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .tq_tick(tq_tick),
    .store_req(store_req), .store_buf(store_buf), .store_mask(store_mask));
  cbt_node_model node_u (.hclk(hclk), .send(send), .pulse_cyc(pulse_cyc),
    .rx_pin(rx_pin));
  // ----------------------------------------------------------------
  // Clock, reset and bus tasks
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Called just after a rising edge; waits on hready, never a fixed count
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic cycles_to(ref logic s, output int c);
    c = 0;
    @(posedge hclk);
    while (s !== 1'b1) begin
      @(posedge hclk);
      c++;
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    results;
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, send} = 4'h0;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    filter_match = 4'h0;
    pulse_cyc = 8'h05;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(32'h00, 32'h00000000);
    rd(32'h04, 32'h00000000);
    rd(32'h08, 32'h00800000);
    rd(32'h30, 32'h00000000);
    chk(hresp, 1'b0);
    // Wake line: filter off, filter on with short and long pulses
    for (int i = 0; i < 3; i++) begin
      ahb(1'b1, 32'h00, (i == 0) ? 32'h0 : 32'h00400000);
      pulse_cyc <= (i == 2) ? 8'h14 : 8'h05;
      send <= 1'b1;
      @(posedge hclk);
      send <= 1'b0;
      lo = 0;
      repeat (40) @(posedge hclk) if (wake_level === 1'b0) lo = 1;
      chk(lo, (i == 1) ? 0 : 1);
    end
    ahb(1'b1, 32'h00, 32'h00072A42);
    rd(32'h00, 32'h00052A42);
    ahb(1'b1, 32'h00, 32'h00070002);
    rd(32'h00, 32'h00010002);
    // Three-sample mode with prescale 2, 14 quanta per bit
    ahb(1'b1, 32'h00, 32'h0003EA42);
    rd(32'h00, 32'h0003EA42);
    ahb(1'b0, 32'h0C, 32'h0);
    chk(q[12:8], 32'd14);
    ahb(1'b1, 32'h08, 32'h0);
    cycles_to(tq_tick, n);
    cycles_to(tq_tick, n);
    chk(n, 5);
    cycles_to(rx_bit_valid, n);
    cycles_to(rx_bit_valid, n);
    chk(n, 83);
    chk(rx_bit, 1'b1);
    // Low run ends just before the sample point: two low ticks outvote one high
    pulse_cyc <= 8'h33;
    send <= 1'b1;
    @(posedge hclk);
    send <= 1'b0;
    cycles_to(rx_bit_valid, n);
    chk(rx_bit, 1'b0);
    ahb(1'b1, 32'h00, 32'h0000FFFF);
    rd(32'h00, 32'h0003EA42);
    // Filters: byte 1 uses the reserved mask
    ahb(1'b1, 32'h04, 32'h0000E2BF);
    rd(32'h04, 32'h0000E2BF);
    filter_match <= 4'h3;
    @(posedge hclk);
    filter_match <= 4'h2;
    #1 chk({store_req, store_mask, store_buf}, 32'h000000BF);
    @(posedge hclk);
    filter_match <= 4'h0;
    #1 chk(store_req, 1'b0);
    @(posedge hclk);
    ahb(1'b1, 32'h04, 32'h00008080);
    rd(32'h04, 32'h0000E2BF);
    ahb(1'b1, 32'h04, 32'h0);
    ahb(1'b1, 32'h04, 32'h0000000A);
    rd(32'h04, 32'h0000000A);
    results;
  end
endmodule
`default_nettype wire
